// ### design/cms_pkg.sv
// constants, register map and state types of the clock mode sequencer
`default_nettype none
package cms_pkg;
  // timing: interval tick from the system clock
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_PERIOD_MS = 5;
  localparam int TICK_CYCLES    = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

  // step list bounds
  localparam logic [4:0] FIRST_STEP = 5'h00;
  localparam logic [4:0] LAST_STEP  = 5'h1f;

  // clock source encodings
  localparam logic [1:0] CLK_FAST = 2'h0;
  localparam logic [1:0] CLK_MID  = 2'h1;
  localparam logic [1:0] CLK_SLOW = 2'h2;
  localparam logic [1:0] CLK_XTAL = 2'h3;

  // operating mode encodings
  localparam logic [1:0] MODE_NORM   = 2'h0;
  localparam logic [1:0] MODE_HALT   = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  localparam logic [1:0] MODE_SNOOZE = 2'h3;

  // indicator patterns in normal mode, run indicator in the msb
  localparam logic [4:0] LED_FAST = 5'h19;
  localparam logic [4:0] LED_XTAL = 5'h1d;
  localparam logic [4:0] LED_MID  = 5'h1a;
  localparam logic [4:0] LED_SLOW = 5'h1b;
  localparam logic [4:0] LED_OFF  = 5'h00;

  // clock switch timeout in interval ticks, value after reset
  localparam logic [7:0] TIMEOUT_TICKS_RESET = 8'h14;

  // boot configuration bytes
  localparam logic [7:0] BOOT_WDT_VALUE   = 8'h6e;
  localparam logic [7:0] BOOT_VDET_VALUE  = 8'h7f;
  localparam logic [7:0] BOOT_FLASH_VALUE = 8'he0;
  localparam logic [7:0] BOOT_DEBUG_VALUE = 8'h84;

  // register indices; byte address is four times the index
  localparam logic [9:0] BOOT_WDT_IDX   = 10'h0c0;
  localparam logic [9:0] BOOT_VDET_IDX  = 10'h0c1;
  localparam logic [9:0] BOOT_FLASH_IDX = 10'h0c2;
  localparam logic [9:0] BOOT_DEBUG_IDX = 10'h0c3;
  localparam logic [9:0] CTRL_IDX       = 10'h000;
  localparam logic [9:0] STATUS_IDX     = 10'h001;

  // status register fields
  localparam int STAT_STEP_LSB   = 0;
  localparam int STAT_CLK_LSB    = 5;
  localparam int STAT_MODE_LSB   = 7;
  localparam int STAT_SWITCH_BIT = 9;
  localparam int STAT_END_BIT    = 10;
  localparam int STAT_ERR_BIT    = 11;

  // sequencer states, gray along wait - switch - wait
  typedef enum logic [1:0] {
    CMS_WAIT   = 2'h0,
    CMS_SWITCH = 2'h1,
    CMS_END    = 2'h3,
    CMS_ERR    = 2'h2
  } cms_state_t;

  // debounce states
  typedef enum logic [1:0] {
    CMS_DB_IDLE  = 2'h0,
    CMS_DB_ARMED = 2'h1,
    CMS_DB_ONE   = 2'h3
  } cms_db_t;
endpackage
`default_nettype wire

// ### design/cms_debounce.sv
// switch synchroniser, falling edge catcher and two-sample debounce
`default_nettype none
module cms_debounce (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // switch pin and interval tick
  input  wire logic switch_pin,
  input  wire logic tick,
  // events
  output logic      switch_edge_irq,
  output logic      press
);
  logic            sw_s1_reg;
  logic            sw_s2_reg;
  logic            sw_s3_reg;
  cms_pkg::cms_db_t db_reg;

  // two flops before anything looks at the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_s1_reg <= 1'b1;
      sw_s2_reg <= 1'b1;
      sw_s3_reg <= 1'b1;
    end else begin
      sw_s1_reg <= switch_pin;
      sw_s2_reg <= sw_s1_reg;
      sw_s3_reg <= sw_s2_reg;
    end
  end

  // R02: falling edge only
  assign switch_edge_irq = sw_s3_reg & ~sw_s2_reg;

  // R03: two tick samples must both read low
  // R23: either high sample drops the press
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_reg <= cms_pkg::CMS_DB_IDLE;
      press  <= 1'b0;
    end else begin
      press <= 1'b0;
      case (db_reg)
        cms_pkg::CMS_DB_IDLE: begin
          if (switch_edge_irq) begin
            db_reg <= cms_pkg::CMS_DB_ARMED;
          end
        end
        cms_pkg::CMS_DB_ARMED: begin
          if (tick) begin
            db_reg <= sw_s2_reg ? cms_pkg::CMS_DB_IDLE : cms_pkg::CMS_DB_ONE;
          end
        end
        cms_pkg::CMS_DB_ONE: begin
          if (tick) begin
            db_reg <= cms_pkg::CMS_DB_IDLE;
            press  <= ~sw_s2_reg;
          end
        end
        default: db_reg <= cms_pkg::CMS_DB_IDLE;
      endcase
    end
  end

  default clocking db_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rise_ignored: assert property ( // R02
    (db_reg == cms_pkg::CMS_DB_IDLE && !sw_s3_reg && sw_s2_reg)
      |=> db_reg == cms_pkg::CMS_DB_IDLE)
    else $error("rising switch edge armed the debounce");
  a_press_low: assert property ( // R23
    $rose(press) |-> !$past(sw_s2_reg) && $past(tick)
      && $past(db_reg) == cms_pkg::CMS_DB_ONE)
    else $error("press accepted without two low samples");
  c_press: cover property (press);
endmodule
`default_nettype wire

// ### design/cms_sequencer.sv
// clock and mode sequencer top: switch driven walk, indicators, apb slave
//
// Contract
// R01: out of reset indicator pins drive, switch input, analog pin analog.
// R02: only a falling switch edge can start a press.
// R03: after the edge sample the switch every 5 ms tick, two agreeing.
// R04: each accepted press moves to the next of 31 steps in order.
// R05: steps 1-13 walk fast, crystal and their halt, stop, snooze modes.
// R06: steps 14-18 are normal: middle, crystal, slow, crystal, middle.
// R07: steps 19-31 walk middle and slow modes, ending fast normal.
// R08: fast clock normal shows on, on, off, off, on.
// R09: crystal clock normal shows on, on, on, off, on.
// R10: run indicator off in halt and stop, on in normal and snooze.
// R11: stop also turns the second indicator off.
// R12: snooze turns the second indicator off, run stays on.
// R13: middle clock normal shows on, on, off, on, off.
// R14: slow clock normal shows on, on, off, on, on.
// R15: a press after step 31 darkens all and halts until reset.
// R16: a clock switch that never completes darkens all and stops; here it darkens all, goes to error, mode unchanged.
// R17: crystal pins set to oscillate, main clock feeds cpu clock.
// R18: flash boot byte selects high speed mode, fast osc 24 MHz.
// R19: watchdog boot byte leaves the counter stopped.
// R20: detector boot byte selects reset mode at 2.81/2.75 V.
// R21: debug boot byte enables on-chip debugging.
// R22: switch timeout is a software count of ticks, expiry is error.
// R23: debounce catches the edge, samples twice, drops on a high.
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
module cms_sequencer #(
  parameter int TICK_CYCLES = cms_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // switch
  input  wire logic        switch_pin,
  // clock generator
  input  wire logic [1:0]  clk_status,
  output logic [1:0]       clk_src_sel,
  output logic [1:0]       power_mode,
  output logic             crystal_pin_osc,
  output logic             main_clock_select,
  // pin setup
  output logic [4:0]       indicator_oe_n,
  output logic             switch_pin_oe_n,
  output logic             analog_channel_pin_analog,
  // indicators
  output logic             run_indicator,
  output logic             second_indicator,
  output logic             crystal_indicator,
  output logic             fourth_indicator,
  output logic             fifth_indicator
);
  localparam int TW = $clog2(TICK_CYCLES);

  // refuse a tick period the counter cannot serve
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  cms_pkg::cms_state_t state_reg;
  logic [4:0]  step_reg;
  logic [1:0]  clk_cur_reg;
  logic [1:0]  clk_sel_reg;
  logic [1:0]  mode_reg;
  logic [4:0]  led_reg;
  logic [7:0]  timeout_reg;
  logic [7:0]  to_cnt_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic        tick;
  logic        init_reg;
  logic [1:0]  cs_s1_reg;
  logic [1:0]  cs_s2_reg;
  logic        press;
  logic [4:0]  tgt_step;
  logic [3:0]  tgt;
  logic        go;
  logic        finish;
  logic        need_sw;
  logic        sw_done;
  logic        time_out;
  logic        apply;

  // clock source and mode for each step, {clock, mode}
  function automatic logic [3:0] step_table(input logic [4:0] s);
    logic [3:0] r;
    r = {cms_pkg::CLK_FAST, cms_pkg::MODE_NORM};
    case (s)
      5'h02, 5'h04, 5'h06, 5'h0f, 5'h11:
        r = {cms_pkg::CLK_XTAL, cms_pkg::MODE_NORM};
      5'h03: r = {cms_pkg::CLK_XTAL, cms_pkg::MODE_HALT};
      5'h05: r = {cms_pkg::CLK_XTAL, cms_pkg::MODE_STOP};
      5'h08: r = {cms_pkg::CLK_FAST, cms_pkg::MODE_HALT};
      5'h0a: r = {cms_pkg::CLK_FAST, cms_pkg::MODE_STOP};
      5'h0c: r = {cms_pkg::CLK_FAST, cms_pkg::MODE_SNOOZE};
      5'h0e, 5'h12, 5'h14, 5'h16, 5'h18, 5'h1a:
        r = {cms_pkg::CLK_MID, cms_pkg::MODE_NORM};
      5'h13: r = {cms_pkg::CLK_MID, cms_pkg::MODE_HALT};
      5'h15: r = {cms_pkg::CLK_MID, cms_pkg::MODE_STOP};
      5'h17: r = {cms_pkg::CLK_MID, cms_pkg::MODE_SNOOZE};
      5'h10, 5'h19, 5'h1c, 5'h1e:
        r = {cms_pkg::CLK_SLOW, cms_pkg::MODE_NORM};
      5'h1d: r = {cms_pkg::CLK_SLOW, cms_pkg::MODE_HALT};
      default: r = {cms_pkg::CLK_FAST, cms_pkg::MODE_NORM};
    endcase
    return r;
  endfunction

  // indicator pattern from clock and mode
  function automatic logic [4:0] led_pattern(input logic [1:0] c,
                                             input logic [1:0] m);
    logic [4:0] p;
    case (c)
      cms_pkg::CLK_XTAL: p = cms_pkg::LED_XTAL;
      cms_pkg::CLK_MID:  p = cms_pkg::LED_MID;
      cms_pkg::CLK_SLOW: p = cms_pkg::LED_SLOW;
      default:           p = cms_pkg::LED_FAST;
    endcase
    case (m)
      cms_pkg::MODE_HALT:   p[4] = 1'b0;
      cms_pkg::MODE_STOP:   p[4:3] = 2'h0;
      cms_pkg::MODE_SNOOZE: p[3] = 1'b0;
      default:              p = p;
    endcase
    return p;
  endfunction

  // 5 ms interval tick; shorten TICK_CYCLES in simulation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= TW'(tick_cnt_reg + 1'b1);
    end
  end
  assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

  // switch front end
  cms_debounce u_debounce (
    .pclk            (pclk),
    .presetn         (presetn),
    .switch_pin      (switch_pin),
    .tick            (tick),
    .switch_edge_irq (),
    .press           (press)
  );

  // clock status comes from the generator's domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_s1_reg <= cms_pkg::CLK_FAST;
      cs_s2_reg <= cms_pkg::CLK_FAST;
    end else begin
      cs_s1_reg <= clk_status;
      cs_s2_reg <= cs_s1_reg;
    end
  end

  // step decisions
  assign finish   = (state_reg == cms_pkg::CMS_WAIT) && press
                    && (step_reg == cms_pkg::LAST_STEP);
  assign go       = (state_reg == cms_pkg::CMS_WAIT) && press
                    && (step_reg != cms_pkg::LAST_STEP);
  assign tgt_step = go ? 5'(step_reg + 5'h01) : step_reg;
  assign tgt      = step_table(tgt_step);
  assign need_sw  = (tgt[3:2] != clk_cur_reg);
  assign sw_done  = (state_reg == cms_pkg::CMS_SWITCH)
                    && (cs_s2_reg == clk_sel_reg);
  assign time_out = (state_reg == cms_pkg::CMS_SWITCH) && !sw_done
                    && tick && (to_cnt_reg == timeout_reg);
  assign apply    = (go && !need_sw) || sw_done;

  // main state and step counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cms_pkg::CMS_WAIT;
      step_reg  <= cms_pkg::FIRST_STEP;
    end else begin
      case (state_reg)
        cms_pkg::CMS_WAIT: begin
          // R15: press past the last step ends the walk
          if (finish) begin
            state_reg <= cms_pkg::CMS_END;
          // R04: strictly one step up per press
          end else if (go) begin
            step_reg <= tgt_step;
            if (need_sw) begin
              state_reg <= cms_pkg::CMS_SWITCH;
            end
          end
        end
        cms_pkg::CMS_SWITCH: begin
          // presses while switching are dropped
          if (sw_done) begin
            state_reg <= cms_pkg::CMS_WAIT;
          // R16: stalled switch abandons the walk
          end else if (time_out) begin
            state_reg <= cms_pkg::CMS_ERR;
          end
        end
        default: state_reg <= state_reg; // only reset leaves end or error
      endcase
    end
  end

  // R22: timeout counts ticks while a switch is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_reg <= 8'h00;
    end else if (state_reg != cms_pkg::CMS_SWITCH) begin
      to_cnt_reg <= 8'h00;
    end else if (tick && to_cnt_reg != timeout_reg) begin
      to_cnt_reg <= 8'(to_cnt_reg + 8'h01);
    end
  end

  // clock select request and the clock now running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_reg <= cms_pkg::CLK_FAST;
      clk_cur_reg <= cms_pkg::CLK_FAST;
    end else begin
      if (go && need_sw) begin
        clk_sel_reg <= tgt[3:2];
      end
      if (sw_done) begin
        clk_cur_reg <= clk_sel_reg;
      end
    end
  end

  // R05: operating mode follows the table once the clock is settled
  // R06: middle, crystal, slow walk in normal mode
  // R07: middle and slow mode walk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= cms_pkg::MODE_NORM;
    end else if (finish) begin
      mode_reg <= cms_pkg::MODE_HALT;
    end else if (apply) begin
      mode_reg <= tgt[1:0];
    end
  end

  // start-up marker, catches the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_reg <= 1'b0;
    end else begin
      init_reg <= 1'b1;
    end
  end

  // indicators; old pattern stays up while a switch is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_reg <= cms_pkg::LED_OFF;
    end else if (!init_reg) begin
      led_reg <= led_pattern(cms_pkg::CLK_FAST, cms_pkg::MODE_NORM);
    // R15: all dark at the end
    end else if (finish) begin
      led_reg <= cms_pkg::LED_OFF;
    // R16: all dark on a stalled switch
    end else if (time_out) begin
      led_reg <= cms_pkg::LED_OFF;
    // R08: fast, R09: crystal, R13: middle, R14: slow patterns
    // R10: run off in halt and stop, R11: stop, R12: snooze
    end else if (apply) begin
      led_reg <= led_pattern(sw_done ? clk_sel_reg : tgt[3:2], tgt[1:0]);
    end
  end

  assign run_indicator     = led_reg[4];
  assign second_indicator  = led_reg[3];
  assign crystal_indicator = led_reg[2];
  assign fourth_indicator  = led_reg[1];
  assign fifth_indicator   = led_reg[0];
  assign clk_src_sel       = clk_sel_reg;
  assign power_mode        = mode_reg;

  // R01: pin directions set once out of reset
  assign indicator_oe_n            = {5{~init_reg}};
  assign switch_pin_oe_n           = 1'b1;
  assign analog_channel_pin_analog = init_reg;
  // R17: crystal oscillation and main clock as cpu clock
  assign crystal_pin_osc   = init_reg;
  assign main_clock_select = init_reg;

  // apb decode; unmapped words answer an error
  logic [9:0]  widx;
  logic        hit;
  logic [31:0] rd_value;
  assign widx = paddr[11:2];
  always_comb begin
    hit      = 1'b1;
    rd_value = 32'h0000_0000;
    if (widx == cms_pkg::CTRL_IDX) begin
      rd_value[7:0] = timeout_reg;
    end else if (widx == cms_pkg::STATUS_IDX) begin
      rd_value[cms_pkg::STAT_STEP_LSB +: 5] = step_reg;
      rd_value[cms_pkg::STAT_CLK_LSB +: 2]  = clk_cur_reg;
      rd_value[cms_pkg::STAT_MODE_LSB +: 2] = mode_reg;
      rd_value[cms_pkg::STAT_SWITCH_BIT] =
        (state_reg == cms_pkg::CMS_SWITCH);
      rd_value[cms_pkg::STAT_END_BIT] = (state_reg == cms_pkg::CMS_END);
      rd_value[cms_pkg::STAT_ERR_BIT] = (state_reg == cms_pkg::CMS_ERR);
    // R19: watchdog stopped after reset
    end else if (widx == cms_pkg::BOOT_WDT_IDX) begin
      rd_value[7:0] = cms_pkg::BOOT_WDT_VALUE;
    // R20: detector reset mode
    end else if (widx == cms_pkg::BOOT_VDET_IDX) begin
      rd_value[7:0] = cms_pkg::BOOT_VDET_VALUE;
    // R18: high speed flash, fast osc 24 MHz
    end else if (widx == cms_pkg::BOOT_FLASH_IDX) begin
      rd_value[7:0] = cms_pkg::BOOT_FLASH_VALUE;
    // R21: debugging enabled
    end else if (widx == cms_pkg::BOOT_DEBUG_IDX) begin
      rd_value[7:0] = cms_pkg::BOOT_DEBUG_VALUE;
    end else begin
      hit = 1'b0;
    end
  end

  // zero wait states; read data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_value;
    end
  end

  // timeout length, the only writable field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_reg <= cms_pkg::TIMEOUT_TICKS_RESET;
    end else if (psel && penable && pwrite && pstrb[0]
                 && widx == cms_pkg::CTRL_IDX) begin
      timeout_reg <= pwdata[7:0];
    end
  end

  default clocking seq_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_step_advance: assert property ( // R04
    go |=> step_reg == $past(step_reg) + 5'h01)
    else $error("step did not advance by one");
  a_end_dark: assert property ( // R15
    finish |=> state_reg == cms_pkg::CMS_END && led_reg == 5'h00
      ##1 state_reg == cms_pkg::CMS_END)
    else $error("end of walk not dark and halted");
  a_error_dark: assert property ( // R16
    state_reg == cms_pkg::CMS_ERR |-> led_reg == 5'h00)
    else $error("error state with lit indicators");
  a_timeout_err: assert property ( // R22
    time_out |=> state_reg == cms_pkg::CMS_ERR)
    else $error("timeout did not reach error");
  a_halt_run_off: assert property ( // R10
    (apply && tgt[1:0] == cms_pkg::MODE_HALT) |=> !run_indicator)
    else $error("run indicator lit in halt");
  a_stop_second: assert property ( // R11
    (apply && tgt[1:0] == cms_pkg::MODE_STOP)
      |=> !run_indicator && !second_indicator)
    else $error("stop pattern wrong");
  a_snooze_second: assert property ( // R12
    (apply && tgt[1:0] == cms_pkg::MODE_SNOOZE)
      |=> run_indicator && !second_indicator)
    else $error("snooze pattern wrong");
  a_crystal_led: assert property ( // R09
    (sw_done && clk_sel_reg == cms_pkg::CLK_XTAL
      && tgt[1:0] == cms_pkg::MODE_NORM) |=> led_reg == 5'h1d)
    else $error("crystal normal pattern wrong");
  a_fast_led: assert property ( // R08
    (apply && tgt == 4'h0) |=> led_reg == 5'h19)
    else $error("fast normal pattern wrong");
  a_pin_setup: assert property ( // R01
    $rose(init_reg) |-> indicator_oe_n == 5'h00 && switch_pin_oe_n
      && analog_channel_pin_analog)
    else $error("pin setup missing after start-up");

  c_finish: cover property (finish);
  c_error: cover property (time_out);
  c_snooze: cover property (mode_reg == cms_pkg::MODE_SNOOZE);
  c_stop: cover property (mode_reg == cms_pkg::MODE_STOP);
endmodule
`default_nettype wire

// ### verif/cms_clk_gen_model.sv
// partner model: clock generator answering source requests
`default_nettype none
module cms_clk_gen_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // request and crystal failure switch
  input  wire logic [1:0] clk_src_sel,
  input  wire logic       xtal_dead,
  // running source
  output logic [1:0]      clk_status
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned wait_cnt;
  // follow a request after a random settle time, prompt or slow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_status <= cms_pkg::CLK_FAST;
      wait_cnt   <= 0;
    end else if (clk_src_sel == clk_status) begin
      wait_cnt <= 0;
    end else if (wait_cnt == 0) begin
      wait_cnt <= 1 + ($urandom % 30);
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end else if (!(xtal_dead && clk_src_sel == cms_pkg::CLK_XTAL)) begin
      clk_status <= clk_src_sel;
    end
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench of the clock mode sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int    TICKS = 20;
  localparam string CLKS  = "FFXXXXXFFFFFFFMXLXMMMMMMMLMFLLLF";
  localparam string MODES = "NNNHNSNNHNSNZNNNNNNHNSNZNNNNNHNN";
  localparam logic [7:0] BOOT [4] = '{8'h6e, 8'h7f, 8'he0, 8'h84};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        switch_pin, xtal_dead, err, osc, mainsel, sw_oe_n, ana;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [1:0]  clk_status, clk_src_sel, power_mode;
  logic [4:0]  oe_n, leds;
  logic [7:0]  tmo;
  int          num_errors, total_checks, cyc, n;

  cms_sequencer #(.TICK_CYCLES(TICKS)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_pin(switch_pin), .clk_status(clk_status),
    .clk_src_sel(clk_src_sel), .power_mode(power_mode),
    .crystal_pin_osc(osc), .main_clock_select(mainsel),
    .indicator_oe_n(oe_n), .switch_pin_oe_n(sw_oe_n),
    .analog_channel_pin_analog(ana), .run_indicator(leds[4]),
    .second_indicator(leds[3]), .crystal_indicator(leds[2]),
    .fourth_indicator(leds[1]), .fifth_indicator(leds[0]));

  cms_clk_gen_model i_clk_gen (
    .pclk(pclk), .presetn(presetn), .clk_src_sel(clk_src_sel),
    .xtal_dead(xtal_dead), .clk_status(clk_status));

  function automatic logic [1:0] exp_clk(int i);
    case (CLKS[i])
      "X": return cms_pkg::CLK_XTAL;
      "M": return cms_pkg::CLK_MID;
      "L": return cms_pkg::CLK_SLOW;
      default: return cms_pkg::CLK_FAST;
    endcase
  endfunction

  function automatic logic [1:0] exp_mode(int i);
    case (MODES[i])
      "H": return cms_pkg::MODE_HALT;
      "S": return cms_pkg::MODE_STOP;
      "Z": return cms_pkg::MODE_SNOOZE;
      default: return cms_pkg::MODE_NORM;
    endcase
  endfunction

  function automatic logic [4:0] exp_led(int i);
    logic [4:0] v;
    case (exp_clk(i))
      cms_pkg::CLK_XTAL: v = 5'h1d;
      cms_pkg::CLK_MID:  v = 5'h1a;
      cms_pkg::CLK_SLOW: v = 5'h1b;
      default:           v = 5'h19;
    endcase
    if (MODES[i] inside {"H", "S"}) v[4] = 1'b0;
    if (MODES[i] inside {"S", "Z"}) v[3] = 1'b0;
    return v;
  endfunction

  task automatic check(logic [32:0] seen, logic [32:0] exp, string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one apb transfer; zero wait states are not assumed
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d,
                     logic [3:0] s);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // hold the switch low, release, let the debounce settle
  task automatic press(int hold);
    @(posedge pclk);
    switch_pin <= 1'b0;
    repeat (hold) @(posedge pclk);
    switch_pin <= 1'b1;
    repeat (3 * TICKS) @(posedge pclk);
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  // clock and hang guard
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, xtal_dead} = '0;
    {paddr, pwdata, pstrb} = '0;
    switch_pin = 1'b1;
    void'($urandom(10614));
    do_reset();
    check({oe_n, sw_oe_n, ana}, 7'h03, "pins");
    check({osc, mainsel}, 2'h3, "clock init");
    check(leds, exp_led(0), "leds start");
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'h300 + 12'(4 * k), 32'h0, 4'h0);
      check(rd, {24'h0, BOOT[k]}, "boot byte");
    end
    apb(1'b1, 12'h300, 32'hff, 4'hf);
    apb(1'b0, 12'h300, 32'h0, 4'h0);
    check(rd, 32'h6e, "boot ro");
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    check({err, rd}, 33'h100000000, "unmapped");
    apb(1'b1, 12'h000, 32'h55, 4'h0);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check({err, rd}, 33'h14, "ctrl reset");
    tmo = 8'h20 + 8'($urandom % 200);
    apb(1'b1, 12'h000, {24'h0, tmo}, 4'h1);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check(rd, {24'h0, tmo}, "ctrl rw");
    // a short glitch must be dropped at the first sample
    press(2);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    check(rd[4:0], 5'h00, "glitch");
    for (int i = 1; i <= 32; i++) begin
      press(3 * TICKS + $urandom % TICKS);
      n = 0;
      while (leds !== (i == 32 ? 5'h00 : exp_led(i)) && n < 300) begin
        @(posedge pclk);
        n++;
      end
      apb(1'b0, 12'h004, 32'h0, 4'h0);
      if (i < 32) begin
        check(leds, exp_led(i), "leds");
        check(power_mode, exp_mode(i), "mode");
        check(clk_src_sel, exp_clk(i), "source");
        check(rd[11:0], {3'h0, exp_mode(i), exp_clk(i), 5'(i)},
              "step");
      end else begin
        check({leds, power_mode}, 7'h01, "end");
        check(rd[11:10], 2'h1, "end flag");
      end
    end
    press(3 * TICKS);
    check(leds, 5'h00, "end stays");
    // second reset, then a crystal that never starts
    xtal_dead <= 1'b1;
    do_reset();
    apb(1'b1, 12'h000, 32'h2, 4'h1);
    press(3 * TICKS);
    press(3 * TICKS);
    repeat (4 * TICKS) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    check(leds, 5'h00, "error leds");
    check(rd[11:10], 2'h2, "error flag");
    press(3 * TICKS);
    check(leds, 5'h00, "error stays");
    stop_test();
  end
endmodule
`default_nettype wire
